// ==== dbgbu_pkg.sv ====
package dbgbu_pkg;

    // ************************************************************
    // Register numbers selected by the move instruction
    // ************************************************************
    localparam logic [2:0] DBGBU_SEL_ADDR0   = 3'h0;
    localparam logic [2:0] DBGBU_SEL_ADDR3   = 3'h3;
    localparam logic [2:0] DBGBU_SEL_STATUS  = 3'h6;
    localparam logic [2:0] DBGBU_SEL_CONTROL = 3'h7;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int DBGBU_NUM_BP       = 4;
    localparam int DBGBU_CTL_ARM_LSB  = 0;   // Local at 2i, global at 2i+1
    localparam int DBGBU_CTL_GUARD    = 13;
    localparam int DBGBU_CTL_TYPE_LSB = 16;  // Type at 16+4i, length at 18+4i
    localparam int DBGBU_CTL_LEN_OFS  = 2;
    localparam int DBGBU_ST_HIT_LSB   = 0;
    localparam int DBGBU_ST_STEP      = 14;
    localparam int DBGBU_ST_TASK      = 15;

    // ************************************************************
    // Writable masks and reset values
    // ************************************************************
    localparam logic [31:0] DBGBU_CTL_MASK    = 32'hFFFF_20FF;
    localparam logic [31:0] DBGBU_ST_MASK     = 32'h0000_C00F;
    localparam logic [31:0] DBGBU_ADDR_RESET  = 32'h0000_0000;
    localparam logic [31:0] DBGBU_CTL_RESET   = 32'h0000_0000;
    localparam logic [31:0] DBGBU_ST_RESET    = 32'h0000_0000;

    // ************************************************************
    // Field encodings
    // ************************************************************
    localparam logic [1:0] DBGBU_TYPE_EXEC  = 2'h0;
    localparam logic [1:0] DBGBU_TYPE_WRITE = 2'h1;
    localparam logic [1:0] DBGBU_TYPE_RDWR  = 2'h3;
    localparam logic [1:0] DBGBU_LEN_1      = 2'h0;
    localparam logic [1:0] DBGBU_LEN_2      = 2'h1;
    localparam logic [1:0] DBGBU_LEN_4      = 2'h3;
    localparam logic [1:0] DBGBU_PRIV_TOP   = 2'h0;

    typedef enum logic [1:0] {
        DBGBU_MOV_DONE,
        DBGBU_MOV_PRIV,
        DBGBU_MOV_GUARD
    } dbgbu_mov_res_t;

endpackage : dbgbu_pkg

// ==== dbgbu_match_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface dbgbu_match_if;
    logic [3:0][31:0] bp_addr;
    logic [3:0][1:0]  bp_type;
    logic [3:0][1:0]  bp_len;
    logic             fetch_valid;
    logic [31:0]      fetch_addr;
    logic             data_valid;
    logic             data_write;
    logic [31:0]      data_addr;
    logic [3:0]       code_hit;
    logic [3:0]       data_hit;

    modport unit (
        output bp_addr, bp_type, bp_len,
        output fetch_valid, fetch_addr, data_valid, data_write, data_addr,
        input  code_hit, data_hit
    );
    modport matcher (
        input  bp_addr, bp_type, bp_len,
        input  fetch_valid, fetch_addr, data_valid, data_write, data_addr,
        output code_hit, data_hit
    );
endinterface : dbgbu_match_if
`default_nettype wire

// ==== dbgbu_matcher.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbgbu_matcher
    import dbgbu_pkg::*;
(
    // Breakpoint settings and access stream
    dbgbu_match_if.matcher mif
);

    // ************************************************************
    // Per-breakpoint comparators
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < DBGBU_NUM_BP; gi = gi + 1) begin : g_bp
            wire logic [31:0] len_mask;
            wire logic        len_ok;
            wire logic        fetch_eq;
            wire logic        data_eq;
            wire logic        type_data;

            // Low bits covered by the length are ignored [RL16] [RL4]
            assign len_mask  = (mif.bp_len[gi] == DBGBU_LEN_4) ? 32'hFFFF_FFFC :
                               (mif.bp_len[gi] == DBGBU_LEN_2) ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
            // Unused length code never matches
            assign len_ok    = (mif.bp_len[gi] != 2'h2);
            assign fetch_eq  = ((mif.fetch_addr ^ mif.bp_addr[gi]) & len_mask) == 32'h0000_0000;
            assign data_eq   = ((mif.data_addr ^ mif.bp_addr[gi]) & len_mask) == 32'h0000_0000;
            // Type selects execute, write only, or read or write [RL3]
            assign type_data = (mif.bp_type[gi] == DBGBU_TYPE_RDWR) ||
                               ((mif.bp_type[gi] == DBGBU_TYPE_WRITE) && mif.data_write);
            assign mif.code_hit[gi] = mif.fetch_valid && fetch_eq && len_ok &&
                                      (mif.bp_type[gi] == DBGBU_TYPE_EXEC);
            assign mif.data_hit[gi] = mif.data_valid && data_eq && len_ok && type_data;
        end
    endgenerate

endmodule : dbgbu_matcher
`default_nettype wire

// ==== dbgbu_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RL1] Four address registers, each qualified by its own type, length and arm bits.
// [RL2] Enabled breakpoint whose type and address match an access raises a debug exception.
// [RL3] Type 00 execute, 01 data write, 11 data read or write; 10 unused.
// [RL4] Length 00 one byte, 01 two bytes, 11 four bytes; 10 unused.
// [RL5] Debug register moves are honoured only at privilege level zero.
// [RL6] Execute breakpoints trap before the matching instruction executes.
// [RL7] Status is never cleared by hardware; software clears it.
// [RL8] At an exception every matching breakpoint sets its hit flag, armed or not.
// [RL9] Task switch into a task with its trap bit set sets the task flag.
// [RL10] Exception caused by single stepping sets the single-step flag.
// [RL11] Global arm bit covers all tasks and survives task switches.
// [RL12] Local arm bit covers the current task and clears on every task switch.
// [RL13] Guard bit blocks debug register access and clears on every debug exception.
// [RL14] With the trap-step flag set, each executed instruction raises an exception.
// [RL15] Breakpoint trap instruction enters the debug path as a code breakpoint; here it raises dbg_exc without dbg_exc_fault.
// [RL16] Comparison ignores low address bits covered by the selected length.
module dbgbu_unit
    import dbgbu_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,

    // Debug register move port
    input  wire logic        mov_valid,
    input  wire logic        mov_write,
    input  wire logic [2:0]  mov_sel,
    input  wire logic [31:0] mov_wdata,
    input  wire logic [1:0]  cur_priv,
    output logic             mov_done,
    output logic             mov_priv_fault,
    output logic             mov_guard_trap,
    output logic [31:0]      mov_rdata,

    // Instruction fetch stream
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_addr,

    // Data access stream
    input  wire logic        data_valid,
    input  wire logic        data_write,
    input  wire logic [31:0] data_addr,

    // Retirement and task events
    input  wire logic        retire_valid,
    input  wire logic        trap_step_flag,
    input  wire logic        brk_insn_exec,
    input  wire logic        task_switch,
    input  wire logic        task_trap_bit,

    // Debug exception request, status and control registers
    output logic             dbg_exc,
    output logic             dbg_exc_fault,
    output logic [31:0]      debug_status_reg,
    output logic [31:0]      debug_control_reg
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [3:0][31:0] breakpoint_address_regs_q;
    logic [31:0]      status_q;
    logic [31:0]      status_d;
    logic [31:0]      control_q;
    logic [31:0]      control_d;
    logic             dbg_exc_q;
    logic             dbg_exc_fault_q;
    logic             mov_done_q;
    logic             mov_priv_q;
    logic             mov_guard_q;
    logic [31:0]      mov_rdata_q;
    logic [31:0]      mov_rdata_d;
    dbgbu_mov_res_t   mov_res;

    // ************************************************************
    // Field extraction
    // ************************************************************
    wire logic [3:0]  local_arm_bit;
    wire logic [3:0]  global_arm_bit;
    wire logic [3:0]  bp_armed;
    wire logic        debug_access_guard;

    dbgbu_match_if mif ();

    genvar gi;
    generate
        for (gi = 0; gi < DBGBU_NUM_BP; gi = gi + 1) begin : g_fld
            // Each breakpoint has its own type, length and arm bits [RL1]
            assign local_arm_bit[gi]  = control_q[DBGBU_CTL_ARM_LSB + 2 * gi];
            assign global_arm_bit[gi] = control_q[DBGBU_CTL_ARM_LSB + 2 * gi + 1];
            assign mif.bp_type[gi]    = control_q[DBGBU_CTL_TYPE_LSB + 4 * gi +: 2];
            assign mif.bp_len[gi]     = control_q[DBGBU_CTL_TYPE_LSB + 4 * gi + DBGBU_CTL_LEN_OFS +: 2];
            // Either arm bit enables the breakpoint [RL11] [RL12]
            assign bp_armed[gi]       = local_arm_bit[gi] | global_arm_bit[gi];
        end
    endgenerate

    assign debug_access_guard = control_q[DBGBU_CTL_GUARD];
    assign mif.bp_addr        = breakpoint_address_regs_q;
    assign mif.fetch_valid    = fetch_valid;
    assign mif.fetch_addr     = fetch_addr;
    assign mif.data_valid     = data_valid;
    assign mif.data_write     = data_write;
    assign mif.data_addr      = data_addr;

    // ************************************************************
    // Address comparators
    // ************************************************************
    dbgbu_matcher u_matcher (
        .mif (mif.matcher)
    );

    // ************************************************************
    // Exception causes
    // ************************************************************
    wire logic        code_exc;
    wire logic        data_exc;
    wire logic        step_exc;
    wire logic        task_exc;
    wire logic        guard_exc;
    wire logic        any_exc;
    wire logic [3:0]  cond_hit;

    // Execute match traps at fetch, before the instruction runs [RL6] [RL2]
    assign code_exc  = |(mif.code_hit & bp_armed);
    // Data match traps after the access [RL2]
    assign data_exc  = |(mif.data_hit & bp_armed);
    // Single step traps after every retired instruction [RL14]
    assign step_exc  = retire_valid && trap_step_flag;
    assign task_exc  = task_switch && task_trap_bit;
    // Conditions recorded whether armed or not [RL8]
    assign cond_hit  = mif.code_hit | mif.data_hit;

    // ************************************************************
    // Move port decode
    // ************************************************************
    wire logic        mov_sel_addr;
    wire logic        mov_sel_status;
    wire logic        mov_sel_ctl;
    wire logic        mov_priv_ok;
    wire logic        mov_take;
    wire logic        wr_addr;
    wire logic        wr_status;
    wire logic        wr_ctl;
    wire logic [1:0]  mov_idx;

    // Only the most privileged level may touch these registers [RL5]
    assign mov_priv_ok    = (cur_priv == DBGBU_PRIV_TOP);
    // Guard set turns an otherwise legal access into a debug trap [RL13]
    assign guard_exc      = mov_valid && mov_priv_ok && debug_access_guard;
    assign mov_take       = mov_valid && mov_priv_ok && !debug_access_guard;
    assign mov_sel_addr   = (mov_sel <= DBGBU_SEL_ADDR3);
    assign mov_sel_status = (mov_sel == DBGBU_SEL_STATUS);
    assign mov_sel_ctl    = (mov_sel == DBGBU_SEL_CONTROL);
    assign mov_idx        = mov_sel[1:0];
    assign wr_addr        = mov_take && mov_write && mov_sel_addr;
    assign wr_status      = mov_take && mov_write && mov_sel_status;
    assign wr_ctl         = mov_take && mov_write && mov_sel_ctl;

    // Trap instruction joins the other causes, but without the fault flag that a code breakpoint raises [RL15]
    assign any_exc = code_exc || data_exc || step_exc || task_exc || guard_exc || brk_insn_exec;

    assign mov_res = !mov_priv_ok ? DBGBU_MOV_PRIV :
                     debug_access_guard ? DBGBU_MOV_GUARD : DBGBU_MOV_DONE;

    // Read data; unmapped numbers read as zero
    assign mov_rdata_d = mov_sel_addr   ? breakpoint_address_regs_q[mov_idx] :
                         mov_sel_status ? status_q :
                         mov_sel_ctl    ? control_q : 32'h0000_0000;

    // ************************************************************
    // Status next value
    // ************************************************************
    // Hardware only ever sets flags, so an event beats a software clear [RL7]
    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = mov_wdata & DBGBU_ST_MASK;
        end
        if (any_exc) begin
            status_d[DBGBU_ST_HIT_LSB +: 4] = status_d[DBGBU_ST_HIT_LSB +: 4] | cond_hit; // [RL8]
        end
        if (step_exc) begin
            status_d[DBGBU_ST_STEP] = 1'b1; // [RL10]
        end
        if (task_exc) begin
            status_d[DBGBU_ST_TASK] = 1'b1; // [RL9]
        end
    end

    // ************************************************************
    // Control next value
    // ************************************************************
    // Exception and task switch act after a software write in the same cycle
    always_comb begin
        control_d = control_q;
        if (wr_ctl) begin
            control_d = mov_wdata & DBGBU_CTL_MASK;
        end
        if (task_switch) begin
            for (int i = 0; i < DBGBU_NUM_BP; i++) begin
                control_d[DBGBU_CTL_ARM_LSB + 2 * i] = 1'b0; // [RL12]
                // Global arm bits are left as they are [RL11]
            end
        end
        if (any_exc) begin
            control_d[DBGBU_CTL_GUARD] = 1'b0; // [RL13]
        end
    end

    // ************************************************************
    // Address registers
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            breakpoint_address_regs_q <= {DBGBU_NUM_BP{DBGBU_ADDR_RESET}};
        end else if (wr_addr) begin
            breakpoint_address_regs_q[mov_idx] <= mov_wdata; // [RL1]
        end
    end

    // ************************************************************
    // Status and control registers
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_q  <= DBGBU_ST_RESET;
            control_q <= DBGBU_CTL_RESET;
        end else begin
            status_q  <= status_d;
            control_q <= control_d;
        end
    end

    // ************************************************************
    // Exception request
    // ************************************************************
    // Registered so the pipeline sees one clean pulse per event [RL2]
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dbg_exc_q       <= 1'b0;
            dbg_exc_fault_q <= 1'b0;
        end else begin
            dbg_exc_q       <= any_exc;
            dbg_exc_fault_q <= code_exc || guard_exc; // [RL6]
        end
    end

    // ************************************************************
    // Move answer
    // ************************************************************
    // Exactly one answer pulse per request, one cycle later
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mov_done_q  <= 1'b0;
            mov_priv_q  <= 1'b0;
            mov_guard_q <= 1'b0;
            mov_rdata_q <= 32'h0000_0000;
        end else begin
            mov_done_q  <= mov_valid && (mov_res == DBGBU_MOV_DONE);
            mov_priv_q  <= mov_valid && (mov_res == DBGBU_MOV_PRIV); // [RL5]
            mov_guard_q <= mov_valid && (mov_res == DBGBU_MOV_GUARD); // [RL13]
            if (mov_take && !mov_write) begin
                mov_rdata_q <= mov_rdata_d;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign mov_done          = mov_done_q;
    assign mov_priv_fault    = mov_priv_q;
    assign mov_guard_trap    = mov_guard_q;
    assign mov_rdata         = mov_rdata_q;
    assign dbg_exc           = dbg_exc_q;
    assign dbg_exc_fault     = dbg_exc_fault_q;
    assign debug_status_reg  = status_q;
    assign debug_control_reg = control_q;

endmodule : dbgbu_unit
`default_nettype wire

// ==== dbgbu_unit_props.sv ====
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Port checker for the breakpoint unit
// ************************************************************
module dbgbu_unit_props
    import dbgbu_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // Move port
    input wire logic        mov_valid,
    input wire logic        mov_write,
    input wire logic [2:0]  mov_sel,
    input wire logic [1:0]  cur_priv,
    input wire logic        mov_done,
    input wire logic        mov_priv_fault,
    input wire logic        mov_guard_trap,
    // Event inputs
    input wire logic        retire_valid,
    input wire logic        trap_step_flag,
    input wire logic        brk_insn_exec,
    input wire logic        task_switch,
    input wire logic        task_trap_bit,
    // Exception and register copies
    input wire logic        dbg_exc,
    input wire logic        dbg_exc_fault,
    input wire logic [31:0] debug_status_reg,
    input wire logic [31:0] debug_control_reg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Any status write attempt may clear bits, so it leaves the sticky check
    logic st_wr;
    logic guard;
    assign st_wr = mov_valid && mov_write && (mov_sel == DBGBU_SEL_STATUS);
    assign guard = debug_control_reg[DBGBU_CTL_GUARD];

    a_priv_refuse: assert property (mov_valid && cur_priv != DBGBU_PRIV_TOP |=> mov_priv_fault && !mov_done)
        else $error("move at low privilege not refused");
    a_move_done: assert property (mov_valid && cur_priv == DBGBU_PRIV_TOP && !guard |=> mov_done && !mov_guard_trap)
        else $error("privileged move not completed");
    a_guard_trap: assert property (mov_valid && cur_priv == DBGBU_PRIV_TOP && guard |=> mov_guard_trap ##[0:1] dbg_exc)
        else $error("guarded move did not trap");
    a_status_sticky: assert property (!st_wr |=> (~debug_status_reg & $past(debug_status_reg)) == 32'h0)
        else $error("status bit cleared by hardware");
    a_step_trap: assert property (retire_valid && trap_step_flag |=> dbg_exc && debug_status_reg[DBGBU_ST_STEP])
        else $error("single step did not trap");
    a_task_flag: assert property (task_switch && task_trap_bit |=> dbg_exc && debug_status_reg[DBGBU_ST_TASK])
        else $error("task switch trap not flagged");
    a_local_clear: assert property (task_switch |=> (debug_control_reg & 32'h0000_0055) == 32'h0)
        else $error("local arm bit survived task switch");
    a_global_keep: assert property (task_switch && !mov_valid |=>
        (debug_control_reg & 32'h0000_00AA) == ($past(debug_control_reg) & 32'h0000_00AA))
        else $error("global arm bit changed on task switch");
    a_guard_clear: assert property (dbg_exc |-> !guard)
        else $error("guard bit still set at exception");
    a_trap_insn: assert property (brk_insn_exec |=> dbg_exc)
        else $error("trap instruction gave no exception");

    // Main scenarios reached
    c_guard: cover property (mov_guard_trap);
    c_exec_bp: cover property (dbg_exc && dbg_exc_fault);
    c_task: cover property (debug_status_reg[DBGBU_ST_TASK]);
endmodule : dbgbu_unit_props

bind dbgbu_unit dbgbu_unit_props u_props (.*);
`default_nettype wire

// ==== dbgbu_pipe_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Pipeline side: fetch, data and event streams
// ************************************************************
module dbgbu_pipe_model (
    // Clock
    input wire logic         sys_clk,
    // Streams into the unit
    output var logic         fetch_valid,
    output var logic [31:0]  fetch_addr,
    output var logic         data_valid,
    output var logic         data_write,
    output var logic [31:0]  data_addr,
    output var logic         retire_valid,
    output var logic         trap_step_flag,
    output var logic         brk_insn_exec,
    output var logic         task_switch,
    output var logic         task_trap_bit
);
    // Quiet at time zero
    initial begin
        {fetch_valid, data_valid, data_write, retire_valid, trap_step_flag} = 5'h00;
        {brk_insn_exec, task_switch, task_trap_bit} = 3'h0;
        fetch_addr = 32'h0;
        data_addr = 32'h0;
    end

    // One cycle of events; addresses go stale afterwards, not held
    task automatic ev(input logic [6:0] k, input logic [31:0] a);
        @(posedge sys_clk);
        #1;
        fetch_valid = k[0];
        data_valid = k[1] | k[2];
        data_write = k[2];
        retire_valid = k[3];
        brk_insn_exec = k[4];
        task_switch = k[5];
        task_trap_bit = k[6];
        fetch_addr = a;
        data_addr = a;
        @(posedge sys_clk);
        #1;
        {fetch_valid, data_valid, retire_valid, brk_insn_exec, task_switch} = 5'h00;
        data_write = ~k[2];
        task_trap_bit = ~k[6];
        fetch_addr = ~a;
        data_addr = ~a;
    endtask : ev

    // Flags register single-step level
    task automatic set_step(input logic v);
        @(posedge sys_clk);
        #1;
        trap_step_flag = v;
    endtask : set_step
endmodule : dbgbu_pipe_model
`default_nettype wire

// ==== dbgbu_unit_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
// ************************************************************
// Bench for the breakpoint unit
// ************************************************************
module dbgbu_unit_test;
    import dbgbu_pkg::*;
    localparam logic [6:0] K_FETCH = 7'h01;
    localparam logic [6:0] K_RD = 7'h02;
    localparam logic [6:0] K_WR = 7'h04;
    localparam logic [6:0] K_RET = 7'h08;
    localparam logic [6:0] K_BRK = 7'h10;
    localparam logic [6:0] K_TSW = 7'h20;
    localparam logic [6:0] K_TTR = 7'h60;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic mov_valid, mov_write, mov_done, mov_priv_fault, mov_guard_trap;
    logic [2:0] mov_sel;
    logic [1:0] cur_priv;
    logic [31:0] mov_wdata, mov_rdata, fetch_addr, data_addr, debug_status_reg, debug_control_reg;
    logic fetch_valid, data_valid, data_write, retire_valid, trap_step_flag;
    logic brk_insn_exec, task_switch, task_trap_bit, dbg_exc, dbg_exc_fault;
    logic [31:0] bp [4] = '{32'h0000_0100, 32'h0000_0203, 32'h0000_0307, 32'h0000_0400};
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    dbgbu_pipe_model pipe (.*);
    dbgbu_unit dut (.*);

    // Clock and hang guard
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // One move request; answer seen in the following cycle
    task automatic mv(input logic w, input logic [2:0] s, input logic [31:0] d, input logic [1:0] p,
                      input logic [2:0] ans);
        @(posedge sys_clk);
        #1;
        {mov_valid, mov_write, mov_sel, mov_wdata, cur_priv} = {1'b1, w, s, d, p};
        @(posedge sys_clk);
        #1;
        mov_valid = 1'b0;
        mov_wdata = ~d;
        `CHK("move answer", ans, {mov_guard_trap, mov_priv_fault, mov_done})
    endtask : mv

    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        mv(1'b1, s, d, 2'h0, 3'b001);
    endtask : wr

    task automatic rd(input logic [2:0] s, input logic [31:0] e);
        mv(1'b0, s, 32'h0, 2'h0, 3'b001);
        `CHK("read data", e, mov_rdata)
    endtask : rd

    // Event, check exception and status, then software clears status
    task automatic probe(input logic [6:0] k, input logic [31:0] a, input logic [1:0] ef, input logic [31:0] st);
        pipe.ev(k, a);
        `CHK("exception", ef, {dbg_exc, dbg_exc_fault})
        `CHK("status", st, debug_status_reg)
        wr(DBGBU_SEL_STATUS, 32'h0);
    endtask : probe

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {mov_valid, mov_write, mov_sel, mov_wdata, cur_priv} = 38'h0;
        repeat (6) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        `CHK("status reset", 32'h0, debug_status_reg)
        `CHK("control reset", 32'h0, debug_control_reg)
        for (int p = 1; p < 4; p++) mv(1'b1, DBGBU_SEL_ADDR0, 32'h0000_0BAD, p[1:0], 3'b010);
        rd(DBGBU_SEL_ADDR0, 32'h0);
        for (int i = 0; i < 4; i++) wr(i[2:0], bp[i]);
        for (int i = 0; i < 4; i++) rd(i[2:0], bp[i]);
        wr(3'h4, 32'hFFFF_FFFF);
        rd(3'h4, 32'h0);
        wr(DBGBU_SEL_CONTROL, 32'h2F50_1FA6);
        rd(DBGBU_SEL_CONTROL, 32'h2F50_00A6);
        wr(DBGBU_SEL_STATUS, 32'hFFFF_FFFF);
        rd(DBGBU_SEL_STATUS, 32'h0000_C00F);
        wr(DBGBU_SEL_STATUS, 32'h0);
        // Each breakpoint type and length, hits and near misses
        probe(K_FETCH, 32'h0000_0100, 2'b11, 32'h1);
        probe(K_FETCH, 32'h0000_0101, 2'b00, 32'h0);
        probe(K_RD, 32'h0000_0100, 2'b00, 32'h0);
        probe(K_RD, 32'h0000_0202, 2'b00, 32'h0);
        probe(K_WR, 32'h0000_0202, 2'b10, 32'h2);
        probe(K_WR, 32'h0000_0201, 2'b00, 32'h0);
        probe(K_RD, 32'h0000_0304, 2'b10, 32'h4);
        probe(K_WR, 32'h0000_0307, 2'b10, 32'h4);
        probe(K_WR, 32'h0000_0308, 2'b00, 32'h0);
        probe(K_WR, 32'h0000_0400, 2'b00, 32'h0);
        probe(K_FETCH, 32'h0000_0203, 2'b00, 32'h0);
        // Flags persist across later cycles, including a non-matching read
        pipe.ev(K_FETCH, 32'h0000_0100);
        pipe.ev(K_RD, 32'h0000_0000);
        `CHK("status kept", 32'h1, debug_status_reg)
        wr(DBGBU_SEL_STATUS, 32'h0);
        // Task switch drops local arming only
        probe(K_TSW, 32'h0, 2'b00, 32'h0);
        `CHK("arm bits", 32'h0000_00A2, debug_control_reg & 32'h0000_00FF)
        probe(K_WR, 32'h0000_0202, 2'b00, 32'h0);
        probe(K_WR | K_BRK, 32'h0000_0202, 2'b10, 32'h2);
        probe(K_TTR, 32'h0, 2'b10, 32'h0000_8000);
        pipe.set_step(1'b1);
        probe(K_RET, 32'h0, 2'b10, 32'h0000_4000);
        pipe.set_step(1'b0);
        probe(K_RET, 32'h0, 2'b00, 32'h0);
        probe(K_BRK, 32'h0, 2'b10, 32'h0);
        // Unused length code on an armed read or write breakpoint never matches
        wr(DBGBU_SEL_CONTROL, 32'hBF50_0080);
        probe(K_WR, 32'h0000_0400, 2'b00, 32'h0);
        // Guarded access traps, leaves target alone, clears guard
        wr(DBGBU_SEL_CONTROL, 32'h2F50_20A2);
        mv(1'b1, DBGBU_SEL_ADDR0, 32'h0000_0BAD, 2'h0, 3'b100);
        @(posedge sys_clk);
        #1;
        `CHK("guard bit", 1'b0, debug_control_reg[DBGBU_CTL_GUARD])
        rd(DBGBU_SEL_ADDR0, bp[0]);
        print_verdict();
    end
endmodule : dbgbu_unit_test
`default_nettype wire
